/* include/ccd_pkg.sv */
// types of the configuration request decoder.
// assumes ccd_regs.svh for the numeric constants.
package ccd_pkg;

  typedef enum logic [7:0]
  {
    CCD_PT_TIME_RES = 8'h20,
    CCD_PT_STEPS = 8'h21,
    CCD_PT_MAP_IN = 8'h22,
    CCD_PT_MAP_OUT = 8'h23,
    CCD_PT_CLEAR = 8'h24,
    CCD_PT_NET_TARGET = 8'h25,
    CCD_PT_NET_SOURCE = 8'h26,
    CCD_PT_PARAM = 8'h27,
    CCD_PT_TUNABLE = 8'h28,
    CCD_PT_NET_PARAM = 8'h29
  } ccd_ptype_e;

  typedef enum logic [7:0]
  {
    CCD_RP_POSITIVE = 8'hB0,
    CCD_RP_NEGATIVE = 8'hB1
  } ccd_reply_e;

  // one stored configuration entry, 112 bits
  typedef struct packed
  {
    logic [7:0] kind;
    logic [15:0] ident;
    logic [15:0] pos;
    logic [63:0] var_ref;
    logic [7:0] dtype;
  } ccd_rec_s;

endpackage

/* include/ccd_regs.svh */
// constants of the configuration request decoder: register offsets,
// byte positions, least lengths, reset values and error codes.
// assumes byte addresses on a 6-bit register port, one 32-bit word each.
`ifndef CCD_REGS_SVH
`define CCD_REGS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CCD_OFF_CTRL 6'h00
`define CCD_OFF_NUMER 6'h04
`define CCD_OFF_DENOM 6'h08
`define CCD_OFF_STEPS 6'h0C
`define CCD_OFF_STEP_IDENT 6'h10
`define CCD_OFF_STATUS 6'h14
`define CCD_OFF_ENTRY_SEL 6'h18
`define CCD_OFF_ENTRY0 6'h1C
`define CCD_OFF_ENTRY1 6'h20
`define CCD_OFF_ENTRY2 6'h24
`define CCD_OFF_ENTRY3 6'h28

// ------------------------------------------------------------
// packet byte positions
// ------------------------------------------------------------
`define CCD_POS_TYPE 0
`define CCD_POS_RECV 3
`define CCD_POS_SEQ_LO 1
`define CCD_POS_SEQ_HI 2
`define CCD_CAP_BYTES 17

// ------------------------------------------------------------
// least packet lengths in bytes
// ------------------------------------------------------------
`define CCD_LEN_TIME_RES 9'h00C
`define CCD_LEN_STEPS 9'h00A
`define CCD_LEN_MAP_IN 9'h011
`define CCD_LEN_MAP_OUT 9'h010
`define CCD_LEN_CLEAR 9'h004
`define CCD_LEN_NET 9'h007
`define CCD_LEN_PARAM 9'h00D
`define CCD_LEN_TUNABLE 9'h011

// ------------------------------------------------------------
// reset values and error codes
// ------------------------------------------------------------
`define CCD_RST_NUMER 32'h0000_0001
`define CCD_RST_DENOM 32'h0000_0001
`define CCD_RST_STEPS 32'h0000_0001
`define CCD_RST_IDENT 8'h00
`define CCD_ERR_NONE 16'h0000
`define CCD_ERR_UNKNOWN 16'h0001
`define CCD_ERR_LENGTH 16'h0002
`define CCD_ERR_SEQ 16'h0003
`define CCD_ERR_STEPS 16'h0004
`define CCD_ERR_FULL 16'h0005

`endif

/* src/ccd_decoder.sv */
// configuration request decoder: parses request packets byte by byte,
// keeps the configuration store and answers each addressed request.
// assumes bytes from same-clock transport logic, little-endian fields.
//
// Contract
// - type 0x20 loads numerator and denominator
// - type 0x21 loads step count and ident
// - type 0x22 stores an input mapping entry
// - type 0x23 stores an output mapping entry
// - type 0x24 erases all stored configuration
// - clearing keeps operating mode and node ident
// - type 0x25 stores target network selector
// - type 0x26 stores source network selector
// - type 0x27 stores fixed parameter reference
// - type 0x28 stores tunable parameter format
// - type 0x29 stores parameter network selector
// - failed request gets negative reply with code
// - accepted request gets positive reply, echoed sequence
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ccd_regs.svh"

module ccd_decoder
  import ccd_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic pkt_valid_in,
  input wire logic [7:0] pkt_byte_in,
  input wire logic pkt_last_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic reply_valid_out,
  output logic [7:0] reply_type_out,
  output logic [15:0] reply_seq_out,
  output logic [7:0] reply_sender_out,
  output logic [15:0] reply_expected_seq_out,
  output logic [15:0] reply_error_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  initial
  begin
    if (DEPTH < 1 || DEPTH > 255)
      $error("ccd_decoder: depth must be 1 to 255");
  end

  // ------------------------------------------------------------
  // decoding helpers
  // ------------------------------------------------------------
  function automatic logic [8:0] least_len(input logic [7:0] t);
    case (t)
      CCD_PT_TIME_RES: least_len = `CCD_LEN_TIME_RES;
      CCD_PT_STEPS: least_len = `CCD_LEN_STEPS;
      CCD_PT_MAP_IN: least_len = `CCD_LEN_MAP_IN;
      CCD_PT_MAP_OUT: least_len = `CCD_LEN_MAP_OUT;
      CCD_PT_CLEAR: least_len = `CCD_LEN_CLEAR;
      CCD_PT_NET_TARGET: least_len = `CCD_LEN_NET;
      CCD_PT_NET_SOURCE: least_len = `CCD_LEN_NET;
      CCD_PT_PARAM: least_len = `CCD_LEN_PARAM;
      CCD_PT_TUNABLE: least_len = `CCD_LEN_TUNABLE;
      CCD_PT_NET_PARAM: least_len = `CCD_LEN_NET;
      default: least_len = 9'h000;
    endcase
  endfunction

  function automatic logic makes_entry(input logic [7:0] t);
    makes_entry = (t >= CCD_PT_MAP_IN && t <= CCD_PT_NET_PARAM && t != CCD_PT_CLEAR);
  endfunction

  // ------------------------------------------------------------
  // byte capture
  // ------------------------------------------------------------
  logic [8:0] cnt_q;
  logic [16:0][7:0] pk_q;
  logic [16:0][7:0] pk_d;

  // the closing byte is merged combinationally so packets may follow back to back
  always_comb
  begin
    pk_d = pk_q;
    if (pkt_valid_in && cnt_q < 9'(`CCD_CAP_BYTES))
      pk_d[cnt_q[4:0]] = pkt_byte_in;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      cnt_q <= 9'h000;
    else if (pkt_valid_in && pkt_last_in)
      cnt_q <= 9'h000;
    else if (pkt_valid_in && cnt_q != 9'h1FF)
      cnt_q <= cnt_q + 9'h001;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      pk_q <= '0;
    else if (pkt_valid_in)
      pk_q <= pk_d;
  end

  // ------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------
  logic [7:0] node_ident_q;
  logic [1:0] op_mode_q;
  logic [15:0] exp_seq_q;
  logic seq_valid_q;
  logic [CW-1:0] count_q;

  logic ev;
  logic [7:0] f_type;
  logic [15:0] f_seq;
  logic [7:0] f_recv;
  logic [8:0] pkt_len;
  logic [8:0] need;
  logic addressed;
  logic nack;
  logic take;
  logic [15:0] err_code;
  ccd_rec_s rec;

  assign ev = pkt_valid_in && pkt_last_in;
  assign f_type = pk_d[`CCD_POS_TYPE];
  assign f_seq = {pk_d[`CCD_POS_SEQ_HI], pk_d[`CCD_POS_SEQ_LO]};
  assign f_recv = pk_d[`CCD_POS_RECV];
  assign pkt_len = (cnt_q == 9'h1FF) ? cnt_q : cnt_q + 9'h001;
  assign need = least_len(f_type);
  assign addressed = ev && f_recv == node_ident_q;
  assign take = addressed && !nack;

  always_comb
  begin
    nack = 1'b1;
    err_code = `CCD_ERR_NONE;
    if (need == 9'h000)
      err_code = `CCD_ERR_UNKNOWN;
    else if (pkt_len < need)
      err_code = `CCD_ERR_LENGTH;
    else if (seq_valid_q && f_seq != exp_seq_q)
      err_code = `CCD_ERR_SEQ;
    else if (f_type == CCD_PT_STEPS && pk_d[7:4] == 32'h0000_0000)
      err_code = `CCD_ERR_STEPS;
    else if (makes_entry(f_type) && count_q == FULL_COUNT)
      err_code = `CCD_ERR_FULL;
    else
      nack = 1'b0;
  end

  // entry fields per type; network tails past byte 6 are not kept
  always_comb
  begin
    rec = '0;
    rec.kind = f_type;
    case (f_type)
      CCD_PT_MAP_IN, CCD_PT_TUNABLE:
      begin
        rec.ident = pk_d[5:4];
        rec.pos = pk_d[7:6];
        rec.var_ref = pk_d[15:8];
        rec.dtype = pk_d[16];
      end
      CCD_PT_MAP_OUT:
      begin
        rec.ident = pk_d[5:4];
        rec.pos = pk_d[7:6];
        rec.var_ref = pk_d[15:8];
      end
      CCD_PT_PARAM:
      begin
        rec.var_ref = pk_d[11:4];
        rec.dtype = pk_d[12];
        rec.pos = 16'(pkt_len - `CCD_LEN_PARAM);
      end
      default:
      begin
        rec.ident = pk_d[5:4];
        rec.dtype = pk_d[6];
      end
    endcase
  end

  // ------------------------------------------------------------
  // sequence tracking
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      seq_valid_q <= 1'b0;
      exp_seq_q <= 16'h0000;
    end
    else if (take)
    begin
      seq_valid_q <= 1'b1;
      exp_seq_q <= f_seq + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // stored configuration
  // ------------------------------------------------------------
  logic [31:0] numer_q;
  logic [31:0] denom_q;
  logic tres_set_q;
  logic [31:0] steps_q;
  logic [15:0] step_ident_q;
  logic steps_set_q;
  logic clear_now;
  logic store_wr;

  assign clear_now = take && f_type == CCD_PT_CLEAR;
  assign store_wr = take && makes_entry(f_type);

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || clear_now)
    begin
      numer_q <= `CCD_RST_NUMER;
      denom_q <= `CCD_RST_DENOM;
      tres_set_q <= 1'b0;
    end
    else if (take && f_type == CCD_PT_TIME_RES)
    begin
      numer_q <= pk_d[7:4];
      denom_q <= pk_d[11:8];
      tres_set_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || clear_now)
    begin
      steps_q <= `CCD_RST_STEPS;
      step_ident_q <= 16'h0000;
      steps_set_q <= 1'b0;
    end
    else if (take && f_type == CCD_PT_STEPS)
    begin
      steps_q <= pk_d[7:4];
      step_ident_q <= pk_d[9:8];
      steps_set_q <= 1'b1;
    end
  end

  // erasing only rewinds the count; old words become unreadable
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || clear_now)
      count_q <= '0;
    else if (store_wr)
      count_q <= count_q + CW'(1);
  end

  logic [CW-1:0] sel_q;
  logic [111:0] entry_rd;

  ccd_store #(
    .WIDTH(112),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_store (
    .core_clk_in(core_clk_in),
    .wr_in(store_wr),
    .waddr_in(count_q[AW-1:0]),
    .wdata_in(rec),
    .raddr_in(sel_q[AW-1:0]),
    .rdata_out(entry_rd)
  );

  // ------------------------------------------------------------
  // replies
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      reply_valid_out <= 1'b0;
      reply_type_out <= 8'h00;
      reply_seq_out <= 16'h0000;
      reply_sender_out <= `CCD_RST_IDENT;
      reply_expected_seq_out <= 16'h0000;
      reply_error_out <= `CCD_ERR_NONE;
    end
    else
    begin
      reply_valid_out <= addressed;
      if (addressed)
      begin
        reply_type_out <= nack ? CCD_RP_NEGATIVE : CCD_RP_POSITIVE;
        reply_seq_out <= f_seq;
        reply_sender_out <= node_ident_q;
        reply_expected_seq_out <= seq_valid_q ? exp_seq_q : f_seq;
        reply_error_out <= err_code;
      end
    end
  end

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  // node ident and mode live apart from the configuration, so clearing spares them
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      node_ident_q <= `CCD_RST_IDENT;
      op_mode_q <= 2'h0;
    end
    else if (reg_wr_in && reg_addr_in == `CCD_OFF_CTRL)
    begin
      node_ident_q <= reg_wdata_in[7:0];
      op_mode_q <= reg_wdata_in[9:8];
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      sel_q <= '0;
    else if (reg_wr_in && reg_addr_in == `CCD_OFF_ENTRY_SEL)
      sel_q <= reg_wdata_in[CW-1:0];
  end

  logic entry_live;
  logic [31:0] rd_val;

  assign entry_live = sel_q < count_q;

  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (reg_addr_in)
      `CCD_OFF_CTRL: rd_val = {22'h0, op_mode_q, node_ident_q};
      `CCD_OFF_NUMER: rd_val = numer_q;
      `CCD_OFF_DENOM: rd_val = denom_q;
      `CCD_OFF_STEPS: rd_val = steps_q;
      `CCD_OFF_STEP_IDENT: rd_val = {16'h0, step_ident_q};
      `CCD_OFF_STATUS: rd_val = {exp_seq_q, 5'h0, seq_valid_q, steps_set_q, tres_set_q, 8'(count_q)};
      `CCD_OFF_ENTRY_SEL: rd_val = 32'(sel_q);
      `CCD_OFF_ENTRY0: rd_val = entry_live ? entry_rd[39:8] : 32'h0;
      `CCD_OFF_ENTRY1: rd_val = entry_live ? entry_rd[71:40] : 32'h0;
      `CCD_OFF_ENTRY2: rd_val = entry_live ? entry_rd[103:72] : 32'h0;
      `CCD_OFF_ENTRY3: rd_val = entry_live ? {16'h0, entry_rd[111:104], entry_rd[7:0]} : 32'h0;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      reg_rdata_out <= 32'h0000_0000;
    else
      reg_rdata_out <= reg_rd_in ? rd_val : 32'h0000_0000;
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_end_for_us;
    addressed;
  endsequence

  sequence s_negative(logic [15:0] code);
    reply_valid_out && reply_type_out == CCD_RP_NEGATIVE && reply_error_out == code;
  endsequence

  a_ack_echo_seq: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_end_for_us ##0 !nack |=> reply_valid_out && reply_type_out == CCD_RP_POSITIVE
      && reply_seq_out == $past(f_seq) && reply_sender_out == $past(node_ident_q))
    else $error("accepted request not answered positively");

  a_nack_unknown: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_end_for_us ##0 need == 9'h000 |=> s_negative(`CCD_ERR_UNKNOWN) and count_q == $past(count_q))
    else $error("unknown type not refused");

  a_nack_short: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_end_for_us ##0 (need != 9'h000 && pkt_len < need) |=> s_negative(`CCD_ERR_LENGTH)
      and numer_q == $past(numer_q) and steps_q == $past(steps_q))
    else $error("short packet not refused");

  a_foreign_ignored: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ev && f_recv != node_ident_q |=> !reply_valid_out && count_q == $past(count_q))
    else $error("foreign packet answered or stored");

  a_zero_steps: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_end_for_us ##0 err_code == `CCD_ERR_STEPS |=> s_negative(`CCD_ERR_STEPS)
      and steps_q == $past(steps_q))
    else $error("zero step count not refused");

  a_time_res_load: assert property (@(posedge core_clk_in) disable iff (rst_in)
    take && f_type == CCD_PT_TIME_RES |=> numer_q == $past(pk_d[7:4]) && denom_q == $past(pk_d[11:8])
      && tres_set_q)
    else $error("time resolution not loaded");

  a_step_load: assert property (@(posedge core_clk_in) disable iff (rst_in)
    take && f_type == CCD_PT_STEPS |=> steps_q == $past(pk_d[7:4]) && step_ident_q == $past(pk_d[9:8]))
    else $error("step count not loaded");

  a_entry_append: assert property (@(posedge core_clk_in) disable iff (rst_in)
    store_wr |=> count_q == $past(count_q) + CW'(1))
    else $error("entry not appended");

  a_clear_keeps_id: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clear_now && !reg_wr_in |=> count_q == '0 && !tres_set_q && !steps_set_q
      && node_ident_q == $past(node_ident_q) && op_mode_q == $past(op_mode_q))
    else $error("clear wrong");

endmodule
`default_nettype wire

/* src/ccd_store.sv */
// configuration entry memory: one write port, one read port.
// assumes a single clock; read data come from a register one cycle after the address.
`timescale 1ns/1ps
`default_nettype none

module ccd_store #(
  parameter int WIDTH = 112,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic core_clk_in,
  input wire logic wr_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [WIDTH-1:0] rdata_out
);

  logic [WIDTH-1:0] mem_q [0:DEPTH-1];

  initial
  begin
    if (DEPTH < 1 || DEPTH > (1 << AW))
      $error("ccd_store: depth does not fit the address width");
  end

  always_ff @(posedge core_clk_in)
  begin
    if (wr_in)
      mem_q[waddr_in] <= wdata_in;
  end

  // unwritten words are never shown: the decoder gates reads by its entry count
  always_ff @(posedge core_clk_in)
  begin
    rdata_out <= mem_q[raddr_in];
  end

endmodule
`default_nettype wire

/* verification/ccd_master_model.sv */
// master side model: hands configuration request packets to the decoder byte by byte.
// assumes the bench calls send_pkt and the decoder samples on rising edges of core_clk_in.
`timescale 1ns/1ps
`default_nettype none

module ccd_master_model (
  input wire logic core_clk_in,
  output var logic pkt_valid_out,
  output var logic [7:0] pkt_byte_out,
  output var logic pkt_last_out
);
  // ------------------------------------------------------------
  // packet sender
  // ------------------------------------------------------------
  initial
  begin
    pkt_valid_out = 1'b0;
    pkt_byte_out = 8'hA5;
    pkt_last_out = 1'b0;
  end

  // steps of zero and unmapped traffic go out only when a scenario asks for them
  // an idle byte line shows the inverse of the last byte, so stale data never pass for fresh
  task automatic send_pkt(input logic [7:0] b[$], input int gap);
    for (int i = 0; i < b.size(); i++)
    begin
      if (i == 2)
      begin
        repeat (gap)
        begin
          @(posedge core_clk_in);
          pkt_valid_out <= 1'b0;
          pkt_byte_out <= ~b[i-1];
        end
      end
      @(posedge core_clk_in);
      pkt_valid_out <= 1'b1;
      pkt_byte_out <= b[i];
      pkt_last_out <= (i == b.size() - 1);
    end
    @(posedge core_clk_in);
    pkt_valid_out <= 1'b0;
    pkt_last_out <= 1'b0;
    pkt_byte_out <= ~b[b.size()-1];
  endtask
endmodule

`default_nettype wire

/* verification/tb_ccd_decoder.sv */
// self-checking bench of the configuration request decoder against a queue-based model.
// assumes the master model drives the packet link and this bench drives the register port.
`timescale 1ns/1ps
`default_nettype none
`include "ccd_regs.svh"

`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("wrong value at %0t ns: got %h expected %h", $time, (g), (e)); \
    end \
  end

module tb_ccd_decoder import ccd_pkg::*;;
  // small store so the full refusal is reached quickly
  localparam int DEPTH = 4;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic pkt_valid, pkt_last, rv, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] pkt_byte, rt, rsnd;
  logic [5:0] reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0, rdata, rdv;
  logic [15:0] rseq, rexp, rerr, sident = 16'h0, nxt;
  logic [31:0] numer = 32'h1, denom = 32'h1, steps = 32'h1;
  logic [9:0] ctrl = 10'h0;
  logic [127:0] ents[$];
  logic [7:0] tl[7] = '{8'h22, 8'h23, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29};
  bit live = 0, tset = 0, sset = 0;
  int n_fail = 0, cmp_count = 0;
  integer seed = 36973;

  // ------------------------------------------------------------
  // clock, partner and design
  // ------------------------------------------------------------
  initial
  begin
    forever #2 core_clk_in = ~core_clk_in;
  end

  ccd_master_model mst (.core_clk_in(core_clk_in), .pkt_valid_out(pkt_valid), .pkt_byte_out(pkt_byte),
    .pkt_last_out(pkt_last));
  ccd_decoder #(.DEPTH(DEPTH)) uut (.core_clk_in(core_clk_in), .rst_in(rst_in), .pkt_valid_in(pkt_valid),
    .pkt_byte_in(pkt_byte), .pkt_last_in(pkt_last), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .reply_valid_out(rv),
    .reply_type_out(rt), .reply_seq_out(rseq), .reply_sender_out(rsnd),
    .reply_expected_seq_out(rexp), .reply_error_out(rerr));

  // ------------------------------------------------------------
  // register port and checks
  // ------------------------------------------------------------
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk_in);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a);
    @(posedge core_clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk_in);
    reg_rd <= 1'b0;
    #1;
    rdv = rdata;
  endtask

  task automatic chk_regs();
    rd(`CCD_OFF_NUMER);
    `CHK(rdv, numer)
    rd(`CCD_OFF_DENOM);
    `CHK(rdv, denom)
    rd(`CCD_OFF_STEPS);
    `CHK(rdv, steps)
    rd(`CCD_OFF_CTRL);
    `CHK(rdv, {22'h0, ctrl})
    rd(`CCD_OFF_STATUS);
    `CHK(rdv[15:0], {5'h0, live, sset, tset, 8'(ents.size())})
    `CHK(rdv[31:16], live ? nxt : 16'h0)
    rd(`CCD_OFF_STEP_IDENT);
    `CHK(rdv, {16'h0, sident})
  endtask

  // every stored entry and the first empty slot, which reads zero
  task automatic readback();
    for (int i = 0; i <= ents.size(); i++)
    begin
      wr(`CCD_OFF_ENTRY_SEL, 32'(i));
      for (int w = 0; w < 4; w++)
      begin
        rd(6'(`CCD_OFF_ENTRY0 + 4 * w));
        `CHK(rdv, (i < ents.size()) ? ents[i][32*w +: 32] : 32'h0)
      end
    end
  endtask

  function automatic int minlen(input logic [7:0] t);
    case (t)
      8'h20: return 12;
      8'h21: return 10;
      8'h22, 8'h28: return 17;
      8'h23: return 16;
      8'h24: return 4;
      8'h27: return 13;
      default: return 7;
    endcase
  endfunction

  // ------------------------------------------------------------
  // one packet: model, send, reply check, model update
  // ------------------------------------------------------------
  task automatic run_pkt(input logic [7:0] t, input logic [7:0] rcv, input int n, input int soff, input bit z,
    input int gap);
    logic [7:0] b[$];
    logic [15:0] s, e;
    logic [63:0] vr;
    logic [7:0] dt;
    logic [31:0] e2;
    s = nxt + 16'(soff);
    for (int i = 0; i < n; i++)
      b.push_back(8'($random(seed)));
    b[0] = t;
    b[1] = s[7:0];
    b[2] = s[15:8];
    b[3] = rcv;
    if (z)
      for (int k = 4; k < 8; k++)
        b[k] = 8'h00;
    e = 16'h0;
    if (t < 8'h20 || t > 8'h29)
      e = 16'h1;
    else if (n < minlen(t))
      e = 16'h2;
    else if (live && s !== nxt)
      e = 16'h3;
    else if (t == 8'h21 && {b[7], b[6], b[5], b[4]} == 32'h0)
      e = 16'h4;
    else if (t > 8'h21 && t != 8'h24 && ents.size() == DEPTH)
      e = 16'h5;
    mst.send_pkt(b, gap);
    #1;
    if (rcv !== ctrl[7:0])
      `CHK(rv, 1'b0)
    else
    begin
      `CHK(rv, 1'b1)
      `CHK(rt, (e != 16'h0) ? CCD_RP_NEGATIVE : CCD_RP_POSITIVE)
      `CHK(rseq, s)
      `CHK(rsnd, ctrl[7:0])
      `CHK(rerr, e)
      `CHK(rexp, live ? nxt : s)
    end
    @(posedge core_clk_in);
    #1;
    `CHK(rv, 1'b0)
    if (rcv !== ctrl[7:0] || e != 16'h0)
      return;
    live = 1;
    nxt = s + 16'h1;
    vr = 64'h0;
    dt = (t == 8'h22 || t == 8'h28) ? b[16] : ((t == 8'h27) ? b[12] : ((t == 8'h23) ? 8'h00 : b[6]));
    e2 = (t == 8'h27) ? {16'h0, 16'(n - 13)} : {b[5], b[4], 16'h0};
    if (t == 8'h22 || t == 8'h23 || t == 8'h28)
      e2 = {b[5], b[4], b[7], b[6]};
    if (t == 8'h22 || t == 8'h23 || t == 8'h27 || t == 8'h28)
      for (int k = 0; k < 8; k++)
        vr[8*k +: 8] = b[((t == 8'h27) ? 4 : 8) + k];
    if (t == 8'h20)
    begin
      numer = {b[7], b[6], b[5], b[4]};
      denom = {b[11], b[10], b[9], b[8]};
      tset = 1;
    end
    else if (t == 8'h21)
    begin
      steps = {b[7], b[6], b[5], b[4]};
      sident = {b[9], b[8]};
      sset = 1;
    end
    else if (t == 8'h24)
    begin
      numer = 32'h1;
      denom = 32'h1;
      steps = 32'h1;
      tset = 0;
      sset = 0;
      sident = 16'h0;
      ents = {};
    end
    else
      ents.push_back({16'h0, t, dt, e2, vr});
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    nxt = 16'($random(seed));
    repeat (6) @(posedge core_clk_in);
    rst_in <= 1'b0;
    chk_regs();
    rd(6'h3C);
    `CHK(rdv, 32'h0)
    wr(`CCD_OFF_NUMER, 32'($random(seed)));
    ctrl = 10'h205;
    wr(`CCD_OFF_CTRL, {22'h0, ctrl});
    chk_regs();
    $display("test reset and registers done");
    run_pkt(8'h20, 8'h05, 12, 0, 0, 0);
    run_pkt(8'h21, 8'h06, 10, 0, 0, 0);
    run_pkt(8'h21, 8'h05, 10, 3, 0, 0);
    run_pkt(8'h21, 8'h05, 10, 0, 1, 0);
    run_pkt(8'h21, 8'h05, 11, 0, 0, 2);
    run_pkt(8'h2A, 8'h05, 8, 0, 0, 0);
    run_pkt(8'h22, 8'h05, 16, 0, 0, 0);
    chk_regs();
    $display("test timing and refusals done");
    for (int i = 0; i < 5; i++)
      run_pkt(tl[i], 8'h05, minlen(tl[i]) + ($random(seed) & 3), 0, 0, i & 1);
    readback();
    chk_regs();
    $display("test store fill done");
    run_pkt(8'h24, 8'h05, 5, 0, 0, 0);
    chk_regs();
    for (int i = 4; i < 7; i++)
      run_pkt(tl[i], 8'h05, minlen(tl[i]) + ($random(seed) & 3), 0, 0, 1);
    readback();
    chk_regs();
    $display("test clear and refill done");
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk_in);
    n_fail++;
    $display("watchdog expired at %0t ns", $time);
    summarize();
  end
endmodule

`default_nettype wire
